// ===== test_pin_function_config_regs.svh
// Offsets, reset values and codes for the test and pin-function registers
`ifndef TEST_PIN_FUNCTION_CONFIG_REGS_SVH
`define TEST_PIN_FUNCTION_CONFIG_REGS_SVH

`define OFS_TRANSMIT_TEST_SELECTOR 10'h00D
`define OFS_VCO_BAND_CALIB_RESULT 10'h3DA
`define OFS_VCO_AMPLITUDE_CALIB_RESULT 10'h3DB
`define OFS_ANALOG_PROBE_SELECT 10'h3F8
`define OFS_SIGNAL_STRENGTH_PROBE_MUX 10'h3F9
`define OFS_GP_PIN_FUNCTION_SELECT 10'h3FA
`define OFS_PROBE_DAC_GAIN 10'h3FD

`define RST_TRANSMIT_TEST_SELECTOR 8'h00
`define RST_CALIB_RESULT 8'h00
`define RST_ANALOG_PROBE_SELECT 8'h00
`define RST_SIGNAL_STRENGTH_PROBE_MUX 8'h00
`define RST_GP_PIN_FUNCTION_SELECT 8'h00
`define RST_PROBE_DAC_GAIN 8'h04

`define PROBE_MUX_LSB 0
`define PROBE_MUX_MSB 1
`define DAC_GAIN_LSB 0
`define DAC_GAIN_MSB 3

`define PROBE_SEL_SIGNAL_STRENGTH 8'h64
`define PROBE_MUX_SIGNAL_STRENGTH 2'h3

`define GPF_SLICER 8'h21
`define GPF_LIMITER 8'h40
`define GPF_LIMITER_FILT 8'h41
`define GPF_TX_DATA 8'h50
`define GPF_PA_RAMP 8'h53
`define GPF_TEST_DAC 8'hC9

`endif

// ===== test_pin_function_config_pkg.sv
// Types shared by the test and pin-function configuration block
package test_pin_function_config_pkg;

	// Register write/read request from the serial control port
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [9:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	// Internal signal sources that may be routed to the pins
	typedef struct packed {
		logic slicer;
		logic lim_i;
		logic lim_q;
		logic lim_i_filt;
		logic lim_q_filt;
		logic tx_data;
		logic pa_ramp_done;
		logic test_dac;
	} pin_src_type;

	// Drive to the general pins: value and enable
	typedef struct packed {
		logic [5:0] value;
		logic [5:0] oe;
	} pin_drive_type;

	typedef enum logic [2:0] {
		TX_NORMAL = 3'b001,
		TX_PREAMBLE = 3'b010,
		TX_CARRIER = 3'b100
	} tx_test_type;

endpackage

// ===== test_pin_function_config.sv
// Test and pin-function configuration registers with pin routing
`timescale 1ns/1ps
`include "test_pin_function_config_regs.svh"

module test_pin_function_config (
	input wire logic core_clk,
	input wire logic rst_b,
	input test_pin_function_config_pkg::reg_req_type reg_req,
	output logic [7:0] reg_rdata,
	input wire logic cal_done,
	input wire logic [7:0] cal_band,
	input wire logic [7:0] cal_ampl,
	input test_pin_function_config_pkg::pin_src_type pin_src,
	input wire logic signal_strength_en_req,
	output test_pin_function_config_pkg::pin_drive_type pin_drive,
	output logic analog_probe_pin_3_en,
	output logic [3:0] probe_dac_gain_out,
	output test_pin_function_config_pkg::tx_test_type tx_test_mode
);
	import test_pin_function_config_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] tx_sel_ff, nxt_tx_sel;
	logic [7:0] band_ff, nxt_band;
	logic [7:0] ampl_ff, nxt_ampl;
	logic [7:0] probe_sel_ff, nxt_probe_sel;
	logic [7:0] probe_mux_ff, nxt_probe_mux;
	logic [7:0] gpf_ff, nxt_gpf;
	logic [7:0] dac_gain_ff, nxt_dac_gain;
	logic [7:0] rdata_ff, nxt_rdata;
	pin_src_type src_meta_ff, src_sync_ff;
	pin_drive_type drive_ff, nxt_drive;
	logic probe_en_ff, nxt_probe_en;
	tx_test_type tx_mode_ff, nxt_tx_mode;

	////////////////////////////////////////////////////////////////////////////
	// Register access
	// Write hit on a given offset
	function automatic logic wr_hit(input reg_req_type req, input logic [9:0] ofs);
		wr_hit = req.wr_en && (req.addr == ofs);
	endfunction

	// Register writes; calibration results only load from the calibrator
	// Writes to the calibration offsets match no branch and are dropped
	always_comb begin
		nxt_tx_sel = tx_sel_ff;
		nxt_probe_sel = probe_sel_ff;
		nxt_probe_mux = probe_mux_ff;
		nxt_gpf = gpf_ff;
		nxt_dac_gain = dac_gain_ff;
		nxt_band = band_ff;
		nxt_ampl = ampl_ff;
		if (wr_hit(reg_req, `OFS_TRANSMIT_TEST_SELECTOR)) begin
			nxt_tx_sel = reg_req.wdata;
		end
		if (wr_hit(reg_req, `OFS_ANALOG_PROBE_SELECT)) begin
			nxt_probe_sel = reg_req.wdata;
		end
		if (wr_hit(reg_req, `OFS_SIGNAL_STRENGTH_PROBE_MUX)) begin
			nxt_probe_mux = reg_req.wdata;
		end
		if (wr_hit(reg_req, `OFS_GP_PIN_FUNCTION_SELECT)) begin
			nxt_gpf = reg_req.wdata;
		end
		if (wr_hit(reg_req, `OFS_PROBE_DAC_GAIN)) begin
			nxt_dac_gain = reg_req.wdata;
		end
		if (cal_done) begin
			nxt_band = cal_band;
			nxt_ampl = cal_ampl;
		end
	end

	// Read mux; unmapped offsets read zero
	// A read meeting a write to the same register returns the old value
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_req.rd_en) begin
			case (reg_req.addr)
				`OFS_TRANSMIT_TEST_SELECTOR: nxt_rdata = tx_sel_ff;
				`OFS_VCO_BAND_CALIB_RESULT: nxt_rdata = band_ff;
				`OFS_VCO_AMPLITUDE_CALIB_RESULT: nxt_rdata = ampl_ff;
				`OFS_ANALOG_PROBE_SELECT: nxt_rdata = probe_sel_ff;
				`OFS_SIGNAL_STRENGTH_PROBE_MUX: nxt_rdata = probe_mux_ff;
				`OFS_GP_PIN_FUNCTION_SELECT: nxt_rdata = gpf_ff;
				`OFS_PROBE_DAC_GAIN: nxt_rdata = dac_gain_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Register bank; calibration copies stay zero until the first load
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sel_ff <= `RST_TRANSMIT_TEST_SELECTOR;
			band_ff <= `RST_CALIB_RESULT;
			ampl_ff <= `RST_CALIB_RESULT;
			probe_sel_ff <= `RST_ANALOG_PROBE_SELECT;
			probe_mux_ff <= `RST_SIGNAL_STRENGTH_PROBE_MUX;
			gpf_ff <= `RST_GP_PIN_FUNCTION_SELECT;
			dac_gain_ff <= `RST_PROBE_DAC_GAIN;
			rdata_ff <= 8'h00;
		end else begin
			tx_sel_ff <= nxt_tx_sel;
			band_ff <= nxt_band;
			ampl_ff <= nxt_ampl;
			probe_sel_ff <= nxt_probe_sel;
			probe_mux_ff <= nxt_probe_mux;
			gpf_ff <= nxt_gpf;
			dac_gain_ff <= nxt_dac_gain;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Source synchroniser; pin sources may come from other analog/digital domains
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			src_meta_ff <= '0;
			src_sync_ff <= '0;
		end else begin
			src_meta_ff <= pin_src;
			src_sync_ff <= src_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin routing; unknown codes leave every pin undriven, the safest choice
	// Routed levels trail their source by three edges: two sync flops, one output flop
	always_comb begin
		nxt_drive = '0;
		case (gpf_ff)
			`GPF_SLICER: begin
				nxt_drive.value[5] = src_sync_ff.slicer;
				nxt_drive.oe[5] = 1'b1;
			end
			`GPF_LIMITER: begin
				nxt_drive.value[0] = src_sync_ff.lim_q;
				nxt_drive.value[1] = src_sync_ff.lim_i;
				nxt_drive.oe[1:0] = 2'b11;
			end
			`GPF_LIMITER_FILT: begin
				nxt_drive.value[0] = src_sync_ff.lim_q_filt;
				nxt_drive.value[1] = src_sync_ff.lim_i_filt;
				nxt_drive.value[2] = src_sync_ff.lim_q;
				nxt_drive.value[3] = src_sync_ff.lim_i;
				nxt_drive.oe[3:0] = 4'hF;
			end
			`GPF_TX_DATA: begin
				nxt_drive.value[0] = src_sync_ff.tx_data;
				nxt_drive.oe[0] = 1'b1;
			end
			`GPF_PA_RAMP: begin
				nxt_drive.value[0] = src_sync_ff.pa_ramp_done;
				nxt_drive.oe[0] = 1'b1;
			end
			`GPF_TEST_DAC: begin
				nxt_drive.value[0] = src_sync_ff.test_dac;
				nxt_drive.oe[0] = 1'b1;
			end
			default: nxt_drive = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Probe and transmit test selection
	// Analog probe gate: both selects must agree
	always_comb begin
		nxt_probe_en = signal_strength_en_req &&
			(probe_sel_ff == `PROBE_SEL_SIGNAL_STRENGTH) &&
			(probe_mux_ff[`PROBE_MUX_MSB:`PROBE_MUX_LSB] == `PROBE_MUX_SIGNAL_STRENGTH);
	end

	// Transmit test decode; reserved values fall back to normal
	// One-hot code lets the modulator test a single bit per mode
	always_comb begin
		case (tx_sel_ff)
			8'h00: nxt_tx_mode = TX_NORMAL;
			8'h02: nxt_tx_mode = TX_PREAMBLE;
			8'h03: nxt_tx_mode = TX_CARRIER;
			default: nxt_tx_mode = TX_NORMAL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Output registers; pins come up undriven so nothing toggles before setup
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_ff <= '0;
			probe_en_ff <= 1'b0;
			tx_mode_ff <= TX_NORMAL;
		end else begin
			drive_ff <= nxt_drive;
			probe_en_ff <= nxt_probe_en;
			tx_mode_ff <= nxt_tx_mode;
		end
	end

	// Ports come straight from flops, so no decode glitch reaches a pin
	assign pin_drive = drive_ff;
	assign analog_probe_pin_3_en = probe_en_ff;
	assign tx_test_mode = tx_mode_ff;
	assign reg_rdata = rdata_ff;
	// Gain passes straight to the converter; only bits 3:0 are used, bits 7:4 are ignored
	assign probe_dac_gain_out = dac_gain_ff[`DAC_GAIN_MSB:`DAC_GAIN_LSB];

endmodule // test_pin_function_config

// ===== test_pin_function_config_sva.sv
// Assertion checker for the test and pin-function configuration block
`timescale 1ns/1ps
`include "test_pin_function_config_regs.svh"
module test_pin_function_config_sva (
	input wire logic core_clk,
	input wire logic rst_b,
	input test_pin_function_config_pkg::reg_req_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic cal_done,
	input wire logic [7:0] cal_band,
	input wire logic [7:0] cal_ampl,
	input test_pin_function_config_pkg::pin_src_type pin_src,
	input wire logic signal_strength_en_req,
	input test_pin_function_config_pkg::pin_drive_type pin_drive,
	input wire logic analog_probe_pin_3_en,
	input wire logic [3:0] probe_dac_gain_out,
	input test_pin_function_config_pkg::tx_test_type tx_test_mode
);
	import test_pin_function_config_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [5:0] oe_exp;
	tx_test_type tx_exp;
	wire logic w_gp = reg_req.wr_en && reg_req.addr == `OFS_GP_PIN_FUNCTION_SELECT;
	wire logic w_gain = reg_req.wr_en && reg_req.addr == `OFS_PROBE_DAC_GAIN;
	wire logic w_tx = reg_req.wr_en && reg_req.addr == `OFS_TRANSMIT_TEST_SELECTOR;
	// Expected enables; unknown codes idle every pin
	always_comb begin
		case (reg_req.wdata)
			`GPF_SLICER: oe_exp = 6'h20;
			`GPF_LIMITER: oe_exp = 6'h03;
			`GPF_LIMITER_FILT: oe_exp = 6'h0F;
			`GPF_TX_DATA, `GPF_PA_RAMP, `GPF_TEST_DAC: oe_exp = 6'h01;
			default: oe_exp = 6'h00;
		endcase
	end
	// Reserved selector values fall back to normal
	assign tx_exp = reg_req.wdata == 8'h02 ? TX_PREAMBLE :
		reg_req.wdata == 8'h03 ? TX_CARRIER : TX_NORMAL;
	////////////////////////////////////////////////////////////////////////
	AST_RESET_VALS: assert property ($rose(rst_b) |-> probe_dac_gain_out == 4'h4
		&& tx_test_mode == TX_NORMAL && pin_drive == '0) else $error("bad reset outputs");
	AST_CAL_BAND: assert property (cal_done ##1 (reg_req.rd_en
		&& reg_req.addr == `OFS_VCO_BAND_CALIB_RESULT) |=> reg_rdata == $past(cal_band, 2))
		else $error("band result wrong");
	AST_CAL_AMPL: assert property (cal_done ##1 (reg_req.rd_en
		&& reg_req.addr == `OFS_VCO_AMPLITUDE_CALIB_RESULT) |=> reg_rdata == $past(cal_ampl, 2))
		else $error("amplitude result wrong");
	AST_PROBE_REQ: assert property (analog_probe_pin_3_en |-> $past(signal_strength_en_req))
		else $error("probe on without source");
	AST_GP_OE: assert property (w_gp |-> ##2 pin_drive.oe == $past(oe_exp, 2))
		else $error("pin enables wrong");
	AST_LIM_VALUE: assert property (pin_drive.oe == 6'h03 && $past(pin_drive.oe, 3) == 6'h03
		|-> pin_drive.value[1:0] == {$past(pin_src.lim_i, 3), $past(pin_src.lim_q, 3)})
		else $error("limiter pins wrong");
	AST_GAIN: assert property (w_gain |-> ##2 probe_dac_gain_out == $past(reg_req.wdata[3:0], 2))
		else $error("gain output wrong");
	AST_TX_MODE: assert property (w_tx |-> ##2 tx_test_mode == $past(tx_exp, 2))
		else $error("transmit test mode wrong");
	COV_CARRIER: cover property (tx_test_mode == TX_CARRIER);
	COV_PROBE: cover property (analog_probe_pin_3_en);
	COV_FILT: cover property (pin_drive.oe == 6'h0F);
endmodule // test_pin_function_config_sva
bind test_pin_function_config test_pin_function_config_sva u_sva (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.reg_req(reg_req),
	.reg_rdata(reg_rdata),
	.cal_done(cal_done),
	.cal_band(cal_band),
	.cal_ampl(cal_ampl),
	.pin_src(pin_src),
	.signal_strength_en_req(signal_strength_en_req),
	.pin_drive(pin_drive),
	.analog_probe_pin_3_en(analog_probe_pin_3_en),
	.probe_dac_gain_out(probe_dac_gain_out),
	.tx_test_mode(tx_test_mode)
);

// ===== test_test_pin_function_config.sv
// Self-checking bench for the test and pin-function configuration block
`timescale 1ns/1ps
`include "test_pin_function_config_regs.svh"
module test_test_pin_function_config;
	import test_pin_function_config_pkg::*;
	reg_req_type reg_req;
	pin_src_type pin_src = '0;
	pin_drive_type pin_drive;
	tx_test_type tx_test_mode;
	logic core_clk, rst_b, cal_done, signal_strength_en_req, analog_probe_pin_3_en;
	logic [7:0] reg_rdata, cal_band, cal_ampl;
	logic [3:0] probe_dac_gain_out;
	int bad_count = 0;
	int total_checks = 0;
	logic [9:0] ra [8] = '{10'h00D, 10'h3DA, 10'h3DB, 10'h3F8, 10'h3F9, 10'h3FA, 10'h3FD, 10'h100};
	// Listed codes plus the unknown code 8'h00 are written; reserved selector values stay untouched
	logic [7:0] gc [9] = '{8'h21, 8'h40, 8'h41, 8'h50, 8'h53, 8'hC9, 8'h00, 8'h40, 8'h00};
	logic [7:0] ge [9] = '{8'h20, 8'h03, 8'h0F, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00};
	logic [7:0] tc [5] = '{8'h02, 8'h03, 8'h00, 8'h02, 8'h00};
	logic [7:0] te [5] = '{8'h02, 8'h04, 8'h01, 8'h02, 8'h01};
	pin_src_type src_d1 = '0;
	pin_src_type src_d2 = '0;
	pin_src_type src_d3 = '0;
	test_pin_function_config u_dut (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.cal_done(cal_done),
		.cal_band(cal_band),
		.cal_ampl(cal_ampl),
		.pin_src(pin_src),
		.signal_strength_en_req(signal_strength_en_req),
		.pin_drive(pin_drive),
		.analog_probe_pin_3_en(analog_probe_pin_3_en),
		.probe_dac_gain_out(probe_dac_gain_out),
		.tx_test_mode(tx_test_mode)
	);
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	// Sources keep moving so routed values really change
	always @(posedge core_clk) pin_src <= #1 pin_src_type'(pin_src + 8'h01);
	// Source as the pins should show it three edges later
	always @(posedge core_clk) begin
		src_d1 <= pin_src;
		src_d2 <= src_d1;
		src_d3 <= src_d2;
	end
	// Expected pin levels per function code, from the routing rules
	function automatic logic [7:0] pin_exp(input logic [7:0] code, input pin_src_type s);
		pin_exp = 8'h00;
		case (code)
			`GPF_SLICER: pin_exp[5] = s.slicer;
			`GPF_LIMITER: pin_exp[1:0] = {s.lim_i, s.lim_q};
			`GPF_LIMITER_FILT: pin_exp[3:0] = {s.lim_i, s.lim_q, s.lim_i_filt, s.lim_q_filt};
			`GPF_TX_DATA: pin_exp[0] = s.tx_data;
			`GPF_PA_RAMP: pin_exp[0] = s.pa_ramp_done;
			`GPF_TEST_DAC: pin_exp[0] = s.test_dac;
			default: pin_exp = 8'h00;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Write, then wait until the outputs have followed
	task wr(input logic [9:0] a, input logic [7:0] d);
		reg_req = '{1'b1, 1'b0, a, d};
		tick(1);
		reg_req = '0;
		tick(2);
	endtask
	task rd(input logic [9:0] a, input logic [7:0] e);
		reg_req = '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		reg_req = '0;
		tick(1);
		chk(reg_rdata, e);
	endtask
	// Watchdog well past the roughly 134 cycles the tests need
	initial begin
		#100000;
		bad_count++;
		close_out;
	end
	initial begin
		rst_b = 0;
		reg_req = '0;
		cal_done = 0;
		cal_band = 8'hA5;
		cal_ampl = 8'h3C;
		signal_strength_en_req = 1;
		tick(10);
		rst_b = 1;
		for (int i = 0; i < 8; i++) rd(ra[i], i == 6 ? 8'h04 : 8'h00);
		chk({4'h0, probe_dac_gain_out}, 8'h04);
		$display("test 1 done");
		for (int i = 0; i < 2; i++) begin
			cal_done = 1;
			tick(1);
			cal_done = 0;
			rd(i ? 10'h3DB : 10'h3DA, i ? 8'h3C : 8'hA5);
		end
		wr(`OFS_VCO_BAND_CALIB_RESULT, 8'hFF);
		rd(`OFS_VCO_BAND_CALIB_RESULT, 8'hA5);
		$display("test 2 done");
		wr(`OFS_PROBE_DAC_GAIN, 8'hF0);
		chk({4'h0, probe_dac_gain_out}, 8'h00);
		rd(`OFS_PROBE_DAC_GAIN, 8'hF0);
		for (int i = 0; i < 9; i++) begin
			wr(`OFS_GP_PIN_FUNCTION_SELECT, gc[i]);
			chk({2'h0, pin_drive.oe}, ge[i]);
			// Levels sampled over four cycles so moving sources show up
			for (int j = 0; j < 4; j++) begin
				chk({2'h0, pin_drive.value} & ge[i], pin_exp(gc[i], src_d3));
				tick(1);
			end
		end
		$display("test 3 done");
		for (int i = 0; i < 5; i++) begin
			wr(`OFS_TRANSMIT_TEST_SELECTOR, tc[i]);
			chk({5'h00, tx_test_mode}, te[i]);
		end
		$display("test 4 done");
		wr(`OFS_ANALOG_PROBE_SELECT, 8'h64);
		wr(`OFS_SIGNAL_STRENGTH_PROBE_MUX, 8'h02);
		chk({7'h00, analog_probe_pin_3_en}, 8'h00);
		wr(`OFS_SIGNAL_STRENGTH_PROBE_MUX, 8'h03);
		chk({7'h00, analog_probe_pin_3_en}, 8'h01);
		signal_strength_en_req = 0;
		tick(2);
		chk({7'h00, analog_probe_pin_3_en}, 8'h00);
		signal_strength_en_req = 1;
		wr(`OFS_ANALOG_PROBE_SELECT, 8'h65);
		chk({7'h00, analog_probe_pin_3_en}, 8'h00);
		$display("test 5 done");
		close_out;
	end
endmodule // test_test_pin_function_config
